// ### sleep_mask_assertions.sv
// port-level property checker for the sleep-state error masking block
`timescale 1ns/1ps
module sleep_mask_assertions
	import sleep_mask_pkg::*;
(
	// clock and resets
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ext_reset_n,
	// register bus
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	// events
	input wire err_events_t events_in,
	input wire err_events_t events_out,
	input wire logic [1:0]  sleep_state_field
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_s0_pass;
		sleep_state_field == 2'b00 |=> events_out == $past(events_in);
	endproperty
	a_s0_pass: assert property (p_s0_pass) else $error("s0 alters events");
	property p_no_spurious;
		1'b1 |=> (events_out & ~$past(events_in)) == '0;
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("event out without event in");
	property p_s45_fans;
		sleep_state_field == 2'b11 |=> events_out.fan_speed_input == 4'h0;
	endproperty
	a_s45_fans: assert property (p_s45_fans) else $error("fan event in s4/5");
	property p_ext_force;
		!ext_reset_n [*4] |=> sleep_state_field == 2'b11;
	endproperty
	a_ext_force: assert property (p_ext_force) else $error("external reset left selector");
	property p_r_upper;
		rvalid |-> rdata[31:8] == 24'h0;
	endproperty
	a_r_upper: assert property (p_r_upper) else $error("read upper bits set");
	property p_b_stands;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_stands: assert property (p_b_stands) else $error("write response dropped");
	property p_r_stands;
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_r_stands: assert property (p_r_stands) else $error("read response dropped");
	property p_r_lat;
		arvalid && arready |=> rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_b_lat;
		awvalid && awready && wvalid && wready && !(bvalid && bready) |=> bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
endmodule

bind sleep_state_error_masking sleep_mask_assertions i_chk (
	.aclk, .aresetn, .ext_reset_n, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .events_in, .events_out, .sleep_state_field
);

// ### sleep_mask_pkg.sv
// constants, types and register map shared by the sleep-state error masking block
package sleep_mask_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int         REG_W              = 8;
	localparam int         IDX_W              = 8;
	localparam int         ADDR_LSB           = 2;
	localparam logic [7:0] IDX_SLEEP_SELECT   = 8'hE4;
	localparam logic [7:0] IDX_S1_GENERAL     = 8'hE5;
	localparam logic [7:0] IDX_S1_TACH        = 8'hE6;
	localparam logic [7:0] IDX_S3_GENERAL     = 8'hE7;
	localparam logic [7:0] IDX_S3_TACH        = 8'hE8;
	localparam logic [7:0] IDX_S3_TEMP_VOLT   = 8'hE9;
	localparam logic [7:0] IDX_S45_GENERAL    = 8'hEA;
	localparam logic [7:0] IDX_S45_TEMP_VOLT  = 8'hEB;

	// ----------------------------------------------------------------
	// reset values and writable fields
	// ----------------------------------------------------------------
	localparam logic [1:0] RST_SLEEP_SELECT   = 2'h3;
	localparam logic [7:0] RST_GENERAL_MASK   = 8'hFF;
	localparam logic [3:0] RST_TACH_MASK      = 4'hF;
	localparam logic [3:0] RST_TEMP_VOLT_MASK = 4'h7;
	localparam int         SELECT_W           = 2;
	localparam int         TACH_W             = 4;
	localparam int         TEMP_VOLT_W        = 4;
	localparam int         BIT_ANALOG13       = 1;
	localparam int         BIT_ANALOG14       = 2;
	localparam int         BIT_THERMAL        = 3;

	// ----------------------------------------------------------------
	// bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY          = 2'h0;
	localparam logic [1:0] RESP_SLVERR        = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SLEEP_S0  = 2'b00,
		SLEEP_S1  = 2'b01,
		SLEEP_S3  = 2'b10,
		SLEEP_S45 = 2'b11
	} sleep_state_t;

	typedef struct packed {
		logic [7:0] general_input;
		logic [3:0] fan_speed_input;
		logic       analog_input_13;
		logic       analog_input_14;
		logic [1:0] zone_temp;
		logic [1:0] zone_diode;
	} err_events_t;

	localparam int EVENT_W = $bits(err_events_t);

	// fixed per-state suppression; S4/5 has no tachometer mask register, fans are taken as stopped
	localparam err_events_t FIXED_NONE = '0;
	localparam err_events_t FIXED_S45_DEFAULT = '{
		general_input:   8'h00,
		fan_speed_input: 4'hF,
		analog_input_13: 1'b0,
		analog_input_14: 1'b0,
		zone_temp:       2'h0,
		zone_diode:      2'h0
	};

endpackage

// ### sleep_state_error_masking.sv
// sleep-state selector, per-state mask registers and error event suppression behind AXI4-Lite
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps

module sleep_state_error_masking
	import sleep_mask_pkg::*;
#(
	parameter int          ADDR_W             = 12,
	parameter err_events_t FIXED_S1_SUPPRESS  = FIXED_NONE,
	parameter err_events_t FIXED_S3_SUPPRESS  = FIXED_NONE,
	parameter err_events_t FIXED_S45_SUPPRESS = FIXED_S45_DEFAULT
) (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// external reset pin, active low, asynchronous to aclk
	input  wire logic              ext_reset_n,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	// axi4-lite write data
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// axi4-lite write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	// axi4-lite read data
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// error events in, masked events out
	input  wire err_events_t       events_in,
	output err_events_t            events_out,
	output logic [1:0]             sleep_state_field
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] addr);
		addr_index = addr[ADDR_LSB +: IDX_W];
	endfunction

	function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
		idx_mapped = (idx >= IDX_SLEEP_SELECT) && (idx <= IDX_S45_TEMP_VOLT);
	endfunction

	// one state's suppression vector from its mask registers and its fixed part
	function automatic err_events_t build_suppress(
		input logic [7:0]             general_mask,
		input logic [TACH_W-1:0]      fan_mask,
		input logic [TEMP_VOLT_W-1:0] tv_mask,
		input err_events_t            fixed
	);
		err_events_t s;
		s                 = fixed;
		s.general_input   = fixed.general_input | general_mask;
		s.fan_speed_input = fixed.fan_speed_input | fan_mask;
		s.analog_input_13 = fixed.analog_input_13 | tv_mask[BIT_ANALOG13];
		s.analog_input_14 = fixed.analog_input_14 | tv_mask[BIT_ANALOG14];
		s.zone_temp       = fixed.zone_temp | {2{tv_mask[BIT_THERMAL]}};
		s.zone_diode      = fixed.zone_diode | {2{tv_mask[BIT_THERMAL]}};
		build_suppress    = s;
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic                   ext_meta_r;
	logic                   ext_sync_r;
	sleep_state_t           select_r;
	logic [7:0]             s1_general_r;
	logic [TACH_W-1:0]      s1_tach_r;
	logic [7:0]             s3_general_r;
	logic [TACH_W-1:0]      s3_tach_r;
	logic [TEMP_VOLT_W-1:0] s3_temp_volt_r;
	logic [7:0]             s45_general_r;
	logic [TEMP_VOLT_W-1:0] s45_temp_volt_r;
	logic                   aw_full_r;
	logic [IDX_W-1:0]       aw_idx_r;
	logic                   w_full_r;
	logic [7:0]             w_byte_r;
	logic                   w_lane_r;
	err_events_t            events_out_r;

	// ----------------------------------------------------------------
	// external reset pin crossing
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_meta_r <= 1'b1;
			ext_sync_r <= 1'b1;
		end else begin
			ext_meta_r <= ext_reset_n;
			ext_sync_r <= ext_meta_r;
		end
	end

	wire ext_hold = !ext_sync_r;

	// ----------------------------------------------------------------
	// write channel: address and data taken in either order
	// ----------------------------------------------------------------
	wire              aw_take  = awvalid && awready;
	wire              w_take   = wvalid && wready;
	wire              aw_have  = aw_full_r || aw_take;
	wire              w_have   = w_full_r || w_take;
	wire              do_write = aw_have && w_have && !bvalid;
	wire [IDX_W-1:0]  wr_idx   = aw_full_r ? aw_idx_r : addr_index(awaddr);
	wire [7:0]        wr_byte  = w_full_r ? w_byte_r : wdata[7:0];
	wire              wr_lane  = w_full_r ? w_lane_r : wstrb[0];
	wire              wr_ok    = idx_mapped(wr_idx);
	wire              wr_en    = do_write && wr_lane && wr_ok && !ext_hold;

	wire wr_select     = wr_en && (wr_idx == IDX_SLEEP_SELECT);
	wire wr_s1_general = wr_en && (wr_idx == IDX_S1_GENERAL);
	wire wr_s1_tach    = wr_en && (wr_idx == IDX_S1_TACH);
	wire wr_s3_general = wr_en && (wr_idx == IDX_S3_GENERAL);
	wire wr_s3_tach    = wr_en && (wr_idx == IDX_S3_TACH);
	wire wr_s3_tv      = wr_en && (wr_idx == IDX_S3_TEMP_VOLT);
	wire wr_s45_general = wr_en && (wr_idx == IDX_S45_GENERAL);
	wire wr_s45_tv     = wr_en && (wr_idx == IDX_S45_TEMP_VOLT);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_idx_r  <= '0;
			awready   <= 1'b1;
		end else begin
			aw_full_r <= aw_have && !do_write;
			awready   <= !(aw_have && !do_write);
			if (aw_take) begin
				aw_idx_r <= addr_index(awaddr);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_byte_r <= '0;
			w_lane_r <= 1'b0;
			wready   <= 1'b1;
		end else begin
			w_full_r <= w_have && !do_write;
			wready   <= !(w_have && !do_write);
			if (w_take) begin
				w_byte_r <= wdata[7:0];
				w_lane_r <= wstrb[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registers; the external reset pin restores all defaults
	// ----------------------------------------------------------------
	wire clear_regs = !aresetn || ext_hold;

	always_ff @(posedge aclk) begin
		if (clear_regs) begin
			select_r <= sleep_state_t'(RST_SLEEP_SELECT);
		end else if (wr_select) begin
			select_r <= sleep_state_t'(wr_byte[SELECT_W-1:0]);
		end
	end

	always_ff @(posedge aclk) begin
		if (clear_regs) begin
			s1_general_r  <= RST_GENERAL_MASK;
			s3_general_r  <= RST_GENERAL_MASK;
			s45_general_r <= RST_GENERAL_MASK;
		end else begin
			if (wr_s1_general) begin
				s1_general_r <= wr_byte;
			end
			if (wr_s3_general) begin
				s3_general_r <= wr_byte;
			end
			if (wr_s45_general) begin
				s45_general_r <= wr_byte;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (clear_regs) begin
			s1_tach_r       <= RST_TACH_MASK;
			s3_tach_r       <= RST_TACH_MASK;
			s3_temp_volt_r  <= RST_TEMP_VOLT_MASK;
			s45_temp_volt_r <= RST_TEMP_VOLT_MASK;
		end else begin
			if (wr_s1_tach) begin
				s1_tach_r <= wr_byte[TACH_W-1:0];
			end
			if (wr_s3_tach) begin
				s3_tach_r <= wr_byte[TACH_W-1:0];
			end
			// bit 0 is stored as written; keeping it high is up to software
			if (wr_s3_tv) begin
				s3_temp_volt_r <= wr_byte[TEMP_VOLT_W-1:0];
			end
			if (wr_s45_tv) begin
				s45_temp_volt_r <= wr_byte[TEMP_VOLT_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// read channel, reserved bits read as zero
	// ----------------------------------------------------------------
	wire             ar_take = arvalid && arready;
	wire [IDX_W-1:0] rd_idx  = addr_index(araddr);
	wire [7:0]       rd_byte =
		(rd_idx == IDX_SLEEP_SELECT)  ? {6'h00, select_r} :
		(rd_idx == IDX_S1_GENERAL)    ? s1_general_r :
		(rd_idx == IDX_S1_TACH)       ? {4'h0, s1_tach_r} :
		(rd_idx == IDX_S3_GENERAL)    ? s3_general_r :
		(rd_idx == IDX_S3_TACH)       ? {4'h0, s3_tach_r} :
		(rd_idx == IDX_S3_TEMP_VOLT)  ? {4'h0, s3_temp_volt_r} :
		(rd_idx == IDX_S45_GENERAL)   ? s45_general_r :
		(rd_idx == IDX_S45_TEMP_VOLT) ? {4'h0, s45_temp_volt_r} :
		8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {24'h000000, rd_byte};
			rresp   <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// suppression per selected state
	// ----------------------------------------------------------------
	// each state's masks feed only its own vector, so the others stay inert
	wire err_events_t sup_s1  = build_suppress(s1_general_r, s1_tach_r,
		{TEMP_VOLT_W{1'b0}}, FIXED_S1_SUPPRESS);
	wire err_events_t sup_s3  = build_suppress(s3_general_r, s3_tach_r,
		s3_temp_volt_r, FIXED_S3_SUPPRESS);
	wire err_events_t sup_s45 = build_suppress(s45_general_r, {TACH_W{1'b0}},
		s45_temp_volt_r, FIXED_S45_SUPPRESS);

	wire err_events_t suppress =
		(select_r == SLEEP_S1)  ? sup_s1 :
		(select_r == SLEEP_S3)  ? sup_s3 :
		(select_r == SLEEP_S45) ? sup_s45 :
		FIXED_NONE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			events_out_r <= FIXED_NONE;
		end else begin
			events_out_r <= events_in & ~suppress;
		end
	end

	assign events_out        = events_out_r;
	assign sleep_state_field = select_r;

endmodule

// ### sleep_state_error_masking_tb_top.sv
// randomised self-checking bench for the sleep-state error masking block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin mismatches++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module sleep_state_error_masking_tb_top
	import sleep_mask_pkg::*;
;
	logic        aclk, aresetn, ext_reset_n, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, sleep_state_field;
	err_events_t events_in, events_out;
	int          mismatches, num_checks, seed, k, s;
	logic [7:0]  m [8];
	logic [7:0]  idx, d;
	localparam logic [7:0] RST_V [8] = '{8'h03, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h07, 8'hFF, 8'h07};
	localparam logic [7:0] WMSK [8] = '{8'h03, 8'hFF, 8'h0F, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'h0F};

	sleep_state_error_masking i_dut (
		.aclk, .aresetn, .ext_reset_n, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .events_in, .events_out, .sleep_state_field
	);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	function automatic logic inr(logic [7:0] i);
		return i >= IDX_SLEEP_SELECT && i <= IDX_S45_TEMP_VOLT;
	endfunction

	function automatic err_events_t expect_ev(err_events_t ev, logic [1:0] st);
		err_events_t sup;
		logic [7:0]  t;
		sup = '0;
		t = 8'h00;
		case (st)
			2'b01: begin
				sup.general_input = m[1];
				sup.fan_speed_input = m[2][3:0];
			end
			2'b10: begin
				sup.general_input = m[3];
				sup.fan_speed_input = m[4][3:0];
				t = m[5];
			end
			2'b11: begin
				sup = FIXED_S45_DEFAULT;
				sup.general_input = m[6];
				t = m[7];
			end
			default: sup = '0;
		endcase
		sup.analog_input_13 = t[BIT_ANALOG13];
		sup.analog_input_14 = t[BIT_ANALOG14];
		sup.zone_temp = {2{t[BIT_THERMAL]}};
		sup.zone_diode = {2{t[BIT_THERMAL]}};
		return ev & ~sup;
	endfunction

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// --------------------------------------------------------------
	// bus master; response ready may lag to exercise slave stalls
	// --------------------------------------------------------------
	task automatic axi_write(input logic [7:0] i, input logic [7:0] v, input logic [3:0] st);
		int   n;
		logic done;
		@(posedge aclk);
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h0, v};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= st[1];
		done = 1'b0;
		for (n = 0; !done; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready) begin
				done = 1'b1;
				bready <= 1'b0;
				`CHK("bresp", inr(i) ? RESP_OKAY : RESP_SLVERR, bresp)
			end else if (n > 0 || st[1])
				bready <= 1'b1;
			if (n > 50) begin
				mismatches++;
				end_of_test();
			end
		end
		if (inr(i) && st[0] && ext_reset_n)
			m[i - IDX_SLEEP_SELECT] = v & WMSK[i - IDX_SLEEP_SELECT];
	endtask

	task automatic axi_read(input logic [7:0] i);
		int   n;
		logic done;
		@(posedge aclk);
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		rready <= i[0];
		done = 1'b0;
		for (n = 0; !done; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready) begin
				done = 1'b1;
				rready <= 1'b0;
				`CHK("rdata", {24'h0, inr(i) ? m[i - IDX_SLEEP_SELECT] : 8'h00}, rdata)
				`CHK("rresp", inr(i) ? RESP_OKAY : RESP_SLVERR, rresp)
			end else if (n > 0 || i[0])
				rready <= 1'b1;
			if (n > 50) begin
				mismatches++;
				end_of_test();
			end
		end
	endtask

	task automatic ev_chk();
		err_events_t ev;
		ev = EVENT_W'($random(seed));
		@(posedge aclk);
		events_in <= ev;
		@(posedge aclk);
		@(posedge aclk);
		`CHK("events_out", expect_ev(ev, m[0][1:0]), events_out)
		`CHK("sleep_state_field", m[0][1:0], sleep_state_field)
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		seed = 32'h7894;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
		ext_reset_n = 1'b1;
		events_in = '0;
		mismatches = 0;
		num_checks = 0;
		m = RST_V;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 0; k < 10; k++)
			axi_read(8'hE3 + 8'(k));
		$display("test reset_values done");
		for (k = 0; k < 30; k++) begin
			idx = IDX_SLEEP_SELECT + 8'({$random(seed)} % 9);
			d = 8'($random(seed));
			if (idx == IDX_S3_TEMP_VOLT)
				d[0] = 1'b1;
			axi_write(idx, d, 4'($random(seed)));
			axi_read(idx);
			for (s = 0; s < 4; s++) begin
				axi_write(IDX_SLEEP_SELECT, (8'($random(seed)) & 8'hFC) | 8'(s), 4'($random(seed)));
				ev_chk();
			end
		end
		$display("test random_masking done");
		axi_write(IDX_SLEEP_SELECT, 8'h00, 4'hF);
		@(posedge aclk);
		ext_reset_n <= 1'b0;
		repeat (6) @(posedge aclk);
		axi_write(IDX_S1_GENERAL, 8'h00, 4'hF);
		ext_reset_n <= 1'b1;
		m = RST_V;
		repeat (4) @(posedge aclk);
		for (k = 0; k < 8; k++)
			axi_read(IDX_SLEEP_SELECT + 8'(k));
		ev_chk();
		$display("test external_reset done");
		end_of_test();
	end
endmodule
